//--- mct_pkg.sv
package mct_pkg;

  localparam logic [15:0] ADDR_PORT0_LATCH = 16'hff00;
  localparam logic [15:0] ADDR_PORT1_LATCH = 16'hff01;
  localparam logic [15:0] ADDR_PORT0_DIR = 16'hff20;
  localparam logic [15:0] ADDR_PORT1_DIR = 16'hff21;
  localparam logic [15:0] ADDR_CODER_CONTROL = 16'hff60;
  localparam logic [15:0] ADDR_BASE_CLOCK_SELECT = 16'hff61;
  localparam logic [15:0] ADDR_BAUD_DIVISOR = 16'hff62;
  localparam logic [15:0] ADDR_CODER_STATUS = 16'hff63;
  localparam logic [15:0] ADDR_TX_BUFFER = 16'hff64;
  localparam logic [15:0] ADDR_BIT_COUNT = 16'hff65;
  localparam logic [15:0] ADDR_ALT_PIN_SELECT = 16'hff70;

  localparam logic [7:0] RST_PORT_DIR = 8'hff;
  localparam logic [7:0] RST_PORT_LATCH = 8'h00;
  localparam logic [7:0] RST_CODER_CONTROL = 8'h10;
  localparam logic [2:0] RST_BASE_CLOCK = 3'h0;
  localparam logic [4:0] RST_BAUD_DIVISOR = 5'h1f;
  localparam logic [7:0] RST_TX_BUFFER = 8'hff;
  localparam logic [2:0] RST_BIT_COUNT = 3'h7;
  localparam logic [7:0] RST_ALT_PIN_SELECT = 8'h00;

  // control register fields
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_FIRST_BIT = 4;
  localparam int CTL_FORMAT_BIT = 1;
  localparam int CTL_IDLE_BIT = 0;
  localparam logic [7:0] CTL_WRITE_MASK = 8'h93;
  localparam logic [7:0] ALT_PIN_WRITE_MASK = 8'h33;
  localparam int ROUTE_BIT = 4;
  localparam int STATUS_BUSY_BIT = 7;
  localparam int CODED_PIN_PORT0 = 0;
  localparam int CODED_PIN_PORT1 = 3;

  localparam logic [4:0] MIN_DIVISOR = 5'h04;
  localparam logic [1:0] LATE_START_TICKS = 2'h2;
  localparam int TX_WORD_WIDTH = 11;
  localparam int TX_FIFO_DEPTH = 2;

endpackage : mct_pkg

//--- mct_fifo.sv
`timescale 1ns/1ps
module mct_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW:0] count_q;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
    ptr_next = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : ptr_next

  assign in_ready_o = (count_q != (PW+1)'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign out_data_o = mem_q[rd_ptr_q];

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || flush_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= ptr_next(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= ptr_next(rd_ptr_q);
      end
      count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : mct_fifo

//--- mct_baud_gen.sv
`timescale 1ns/1ps
module mct_baud_gen (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [2:0] base_code_i,
  input wire logic [4:0] divisor_i,
  output logic base_tick_o,
  output logic baud_o,
  output logic bit_end_o,
  output logic window_o
);
  logic [4:0] pre_q;
  logic [4:0] kcnt_q;
  logic half_q;

  // codes 110 and 111 are undefined; they fall back to the slowest rate
  function automatic logic [4:0] base_mask(input logic [2:0] code);
    case (code)
      3'h0: base_mask = 5'h00;
      3'h1: base_mask = 5'h01;
      3'h2: base_mask = 5'h03;
      3'h3: base_mask = 5'h07;
      3'h4: base_mask = 5'h0f;
      default: base_mask = 5'h1f;
    endcase
  endfunction : base_mask

  function automatic logic [4:0] eff_k(input logic [4:0] div);
    eff_k = (div < mct_pkg::MIN_DIVISOR) ? mct_pkg::MIN_DIVISOR : div;
  endfunction : eff_k

  wire [4:0] mask = base_mask(base_code_i);
  wire [4:0] k_val = eff_k(divisor_i);
  wire k_wrap = (kcnt_q == k_val - 5'h01);

  assign base_tick_o = ((pre_q & mask) == mask);
  assign baud_o = half_q;
  assign bit_end_o = run_i && base_tick_o && k_wrap && half_q;
  // half a baud period plus one base clock before the bit ends
  assign window_o = run_i && base_tick_o && !half_q && (kcnt_q == k_val - 5'h02);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 5'h01;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !run_i) begin
      kcnt_q <= '0;
      half_q <= 1'b0;
    end else if (base_tick_o) begin
      kcnt_q <= k_wrap ? 5'h00 : kcnt_q + 5'h01;
      half_q <= k_wrap ? !half_q : half_q;
    end
  end
endmodule : mct_baud_gen

//--- mct_top.sv
`timescale 1ns/1ps
// Summary of operation
// - the unit sends only while control bit 7 is set; otherwise stopped.
// - first-bit select 0 sends most significant first, 1 least significant.
// - format select 0 gives Manchester output, 1 plain bit output.
// - outside a transfer the output rests at the idle level bit.
// - base clock field picks system clock divided by 1 to 32.
// - divisor k is the field value, with values below 4 acting as 4.
// - bit period is two k base clocks; baud clock is divided again by two.
// - routing bit 4 selects port 0 bit 0 or port 1 bit 3.
// - direction bit 0 enables the pin driver; direction registers reset to ones.
// - Manchester mode sends units of 1 to 8 bits, each bit coded.
// - buffer write while enabled starts sending; count and data load together.
// - the start interrupt pulses when buffer data moves into the shifter.
// - the shifter advances each baud period; Manchester XORs bit with baud clock.
// - last bit is at count zero; early writes follow on without gap.
// - a write in the late window starts the next unit two base clocks later.
// - busy reads one while sending; reset, disable or running dry clears it.
// - bit count field gives length value plus one, reset value seven.
// - short units always take the low-order bits of the buffer.
module mct_top (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [15:0] bus_addr_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [7:0] bus_wdata_i,
  output logic [7:0] bus_rdata_o,
  output logic [7:0] port0_out_o,
  output logic [7:0] port0_oe_o,
  output logic [7:0] port1_out_o,
  output logic [7:0] port1_oe_o,
  output logic tx_start_interrupt_o,
  output logic tx_buffer_full_o
);
  typedef enum logic [1:0] {
    MCT_IDLE,
    MCT_SEND,
    MCT_GAP
  } mct_state_t;

  mct_state_t state_q;
  mct_state_t state_d;

  logic [7:0] port0_direction_q;
  logic [7:0] port1_direction_q;
  logic [7:0] port0_latch_q;
  logic [7:0] port1_latch_q;
  logic [7:0] coder_control_q;
  logic [2:0] base_clock_field_q;
  logic [4:0] baud_divisor_field_q;
  logic [7:0] tx_buffer_q;
  logic [2:0] bit_count_q;
  logic [7:0] alt_pin_select_q;

  logic [7:0] shift_q;
  logic [2:0] cnt_q;
  logic pend_ok_q;
  logic [1:0] gap_q;
  logic coded_q;
  logic irq_q;
  logic full_q;
  logic [7:0] rdata_q;
  logic [7:0] p0_out_q;
  logic [7:0] p0_oe_q;
  logic [7:0] p1_out_q;
  logic [7:0] p1_oe_q;

  // register decode
  wire hit_p0l = (bus_addr_i == mct_pkg::ADDR_PORT0_LATCH);
  wire hit_p1l = (bus_addr_i == mct_pkg::ADDR_PORT1_LATCH);
  wire hit_p0d = (bus_addr_i == mct_pkg::ADDR_PORT0_DIR);
  wire hit_p1d = (bus_addr_i == mct_pkg::ADDR_PORT1_DIR);
  wire hit_ctl = (bus_addr_i == mct_pkg::ADDR_CODER_CONTROL);
  wire hit_bcs = (bus_addr_i == mct_pkg::ADDR_BASE_CLOCK_SELECT);
  wire hit_div = (bus_addr_i == mct_pkg::ADDR_BAUD_DIVISOR);
  wire hit_sts = (bus_addr_i == mct_pkg::ADDR_CODER_STATUS);
  wire hit_txb = (bus_addr_i == mct_pkg::ADDR_TX_BUFFER);
  wire hit_bit = (bus_addr_i == mct_pkg::ADDR_BIT_COUNT);
  wire hit_alt = (bus_addr_i == mct_pkg::ADDR_ALT_PIN_SELECT);

  // control fields
  wire unit_enable = coder_control_q[mct_pkg::CTL_ENABLE_BIT];
  wire first_bit_select = coder_control_q[mct_pkg::CTL_FIRST_BIT];
  wire format_select = coder_control_q[mct_pkg::CTL_FORMAT_BIT];
  wire idle_level_select = coder_control_q[mct_pkg::CTL_IDLE_BIT];
  wire coder_pin_route = alt_pin_select_q[mct_pkg::ROUTE_BIT];
  wire tx_busy_flag = (state_q != MCT_IDLE);

  // baud generation
  wire base_tick;
  wire baud_clk;
  wire bit_end;
  wire window;
  wire sending = (state_q == MCT_SEND);

  mct_baud_gen u_baud (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .run_i(sending),
    .base_code_i(base_clock_field_q),
    .divisor_i(baud_divisor_field_q),
    .base_tick_o(base_tick),
    .baud_o(baud_clk),
    .bit_end_o(bit_end),
    .window_o(window)
  );

  // pending units, snapshot of bit count taken at the buffer write
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [mct_pkg::TX_WORD_WIDTH-1:0] fifo_out_data;
  wire buf_write = bus_wr_i && hit_txb;
  wire fifo_push = buf_write && unit_enable;
  wire load;

  mct_fifo #(
    .WIDTH(mct_pkg::TX_WORD_WIDTH),
    .DEPTH(mct_pkg::TX_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .flush_i(!unit_enable),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i({bit_count_q, bus_wdata_i}),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(load),
    .out_data_o(fifo_out_data)
  );

  wire [2:0] next_len = fifo_out_data[10:8];
  wire [7:0] next_data = fifo_out_data[7:0];
  wire last_bit = (cnt_q == 3'h0);
  wire unit_done = sending && bit_end && last_bit;
  wire gap_done = (state_q == MCT_GAP) && base_tick && (gap_q == mct_pkg::LATE_START_TICKS - 2'h1);

  // start: from idle, gapless follow-on, or late follow-on after the gap
  assign load = unit_enable && fifo_out_valid && ((state_q == MCT_IDLE)
      || (unit_done && pend_ok_q) || gap_done);

  // low-order bits first aligned to the top when sending msb first
  wire [7:0] msb_aligned = 8'(next_data << (3'h7 - next_len));
  wire cur_bit = first_bit_select ? shift_q[0] : shift_q[7];
  wire manch_bit = cur_bit ^ baud_clk;
  wire coded_d = !sending ? idle_level_select : (format_select ? cur_bit : manch_bit);

  always_comb begin
    state_d = state_q;
    case (state_q)
      MCT_IDLE: begin
        if (load) begin
          state_d = MCT_SEND;
        end
      end
      MCT_SEND: begin
        if (unit_done && !load) begin
          state_d = fifo_out_valid ? MCT_GAP : MCT_IDLE;
        end
      end
      MCT_GAP: begin
        if (!fifo_out_valid) begin
          state_d = MCT_IDLE;
        end else if (load) begin
          state_d = MCT_SEND;
        end
      end
      default: state_d = MCT_IDLE;
    endcase
    if (!unit_enable) begin
      state_d = MCT_IDLE;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_q <= MCT_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // shifter and bit counter
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      shift_q <= '0;
      cnt_q <= '0;
    end else if (load) begin
      shift_q <= first_bit_select ? next_data : msb_aligned;
      cnt_q <= next_len;
    end else if (sending && bit_end && !last_bit) begin
      shift_q <= first_bit_select ? {1'b0, shift_q[7:1]} : {shift_q[6:0], 1'b0};
      cnt_q <= cnt_q - 3'h1;
    end
  end

  // was the next unit already waiting when the late window opened
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !sending) begin
      pend_ok_q <= 1'b0;
    end else if (window && last_bit) begin
      pend_ok_q <= fifo_out_valid;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || state_q != MCT_GAP) begin
      gap_q <= '0;
    end else if (base_tick) begin
      gap_q <= gap_q + 2'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      coded_q <= 1'b0;
      irq_q <= 1'b0;
      full_q <= 1'b0;
    end else begin
      coded_q <= coded_d;
      irq_q <= load;
      full_q <= !fifo_in_ready;
    end
  end

  // register writes; mode bits are used live, software keeps them still while enabled
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      port0_direction_q <= mct_pkg::RST_PORT_DIR;
      port1_direction_q <= mct_pkg::RST_PORT_DIR;
      port0_latch_q <= mct_pkg::RST_PORT_LATCH;
      port1_latch_q <= mct_pkg::RST_PORT_LATCH;
      coder_control_q <= mct_pkg::RST_CODER_CONTROL;
      base_clock_field_q <= mct_pkg::RST_BASE_CLOCK;
      baud_divisor_field_q <= mct_pkg::RST_BAUD_DIVISOR;
      tx_buffer_q <= mct_pkg::RST_TX_BUFFER;
      bit_count_q <= mct_pkg::RST_BIT_COUNT;
      alt_pin_select_q <= mct_pkg::RST_ALT_PIN_SELECT;
    end else if (bus_wr_i) begin
      if (hit_p0d) begin
        port0_direction_q <= bus_wdata_i;
      end
      if (hit_p1d) begin
        port1_direction_q <= bus_wdata_i;
      end
      if (hit_p0l) begin
        port0_latch_q <= bus_wdata_i;
      end
      if (hit_p1l) begin
        port1_latch_q <= bus_wdata_i;
      end
      if (hit_ctl) begin
        coder_control_q <= bus_wdata_i & mct_pkg::CTL_WRITE_MASK;
      end
      if (hit_bcs) begin
        base_clock_field_q <= bus_wdata_i[2:0];
      end
      if (hit_div) begin
        baud_divisor_field_q <= bus_wdata_i[4:0];
      end
      if (hit_txb) begin
        tx_buffer_q <= bus_wdata_i;
      end
      if (hit_bit) begin
        bit_count_q <= bus_wdata_i[2:0];
      end
      if (hit_alt) begin
        alt_pin_select_q <= bus_wdata_i & mct_pkg::ALT_PIN_WRITE_MASK;
      end
    end
  end

  // read port; unmapped addresses read zero
  wire [7:0] rd_mux = hit_p0l ? port0_latch_q
      : hit_p1l ? port1_latch_q
      : hit_p0d ? port0_direction_q
      : hit_p1d ? port1_direction_q
      : hit_ctl ? coder_control_q
      : hit_bcs ? {5'h00, base_clock_field_q}
      : hit_div ? {3'h0, baud_divisor_field_q}
      : hit_sts ? {tx_busy_flag, 7'h00}
      : hit_txb ? tx_buffer_q
      : hit_bit ? {5'h00, bit_count_q}
      : hit_alt ? alt_pin_select_q
      : 8'h00;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else if (bus_rd_i) begin
      rdata_q <= rd_mux;
    end
  end

  // pins: coded output replaces the latch only on the routed pin while enabled
  wire use_p0 = unit_enable && !coder_pin_route;
  wire use_p1 = unit_enable && coder_pin_route;
  wire [7:0] p0_sel = 8'(use_p0) << mct_pkg::CODED_PIN_PORT0;
  wire [7:0] p1_sel = 8'(use_p1) << mct_pkg::CODED_PIN_PORT1;
  wire [7:0] p0_drive = (port0_latch_q & ~p0_sel) | ({8{coded_q}} & p0_sel);
  wire [7:0] p1_drive = (port1_latch_q & ~p1_sel) | ({8{coded_q}} & p1_sel);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      p0_out_q <= 8'h00;
      p1_out_q <= 8'h00;
      p0_oe_q <= 8'h00;
      p1_oe_q <= 8'h00;
    end else begin
      p0_out_q <= p0_drive;
      p1_out_q <= p1_drive;
      p0_oe_q <= ~port0_direction_q;
      p1_oe_q <= ~port1_direction_q;
    end
  end

  assign bus_rdata_o = rdata_q;
  assign port0_out_o = p0_out_q;
  assign port0_oe_o = p0_oe_q;
  assign port1_out_o = p1_out_q;
  assign port1_oe_o = p1_oe_q;
  assign tx_start_interrupt_o = irq_q;
  assign tx_buffer_full_o = full_q;
endmodule : mct_top

//--- mct_rx_model.sv
`timescale 1ns/1ps
module mct_rx_model (
  input wire logic ref_clk_i,
  input wire logic line_i,
  output logic [1023:0] hist_o
);
  // long trail of line samples, newest in bit 0; the bench decodes it
  always @(posedge ref_clk_i) begin
    hist_o <= {hist_o[1022:0], line_i};
  end
endmodule : mct_rx_model

//--- mct_top_properties.sv
`timescale 1ns/1ps
module mct_checker (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [15:0] bus_addr_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic [7:0] bus_rdata_o,
  input wire logic [7:0] port0_out_o,
  input wire logic [7:0] port0_oe_o,
  input wire logic [7:0] port1_out_o,
  input wire logic [7:0] port1_oe_o,
  input wire logic tx_start_interrupt_o,
  input wire logic tx_buffer_full_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic en_q;
  logic route_q;
  logic fresh_q;
  wire ctl_wr = bus_wr_i && bus_addr_i == mct_pkg::ADDR_CODER_CONTROL;
  wire alt_wr = bus_wr_i && bus_addr_i == mct_pkg::ADDR_ALT_PIN_SELECT;
  wire tx_wr = bus_wr_i && bus_addr_i == mct_pkg::ADDR_TX_BUFFER;
  // fresh: first buffer write after enabling from stop
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
      route_q <= 1'b0;
      fresh_q <= 1'b0;
    end else begin
      if (ctl_wr) begin
        en_q <= bus_wdata_i[7];
        fresh_q <= bus_wdata_i[7] && !en_q;
      end else if (tx_wr) begin
        fresh_q <= 1'b0;
      end
      if (alt_wr) begin
        route_q <= bus_wdata_i[4];
      end
    end
  end
  a_irq_spacing: assert property (
    tx_start_interrupt_o |=> !tx_start_interrupt_o [*7]) else $error("start pulses too close");
  a_irq_enabled: assert property (
    tx_start_interrupt_o |-> $past(en_q)) else $error("start pulse while stopped");
  a_irq_start: assert property (
    tx_wr && en_q && fresh_q |-> ##[1:4] tx_start_interrupt_o) else $error("no start pulse");
  a_stop_quiet: assert property (
    (!en_q && !bus_wr_i) [*5] |-> $stable(port0_out_o[0]) && $stable(port1_out_o[3]))
    else $error("coded pin moves while stopped");
  a_route_other: assert property (
    (en_q && !bus_wr_i) [*3] |->
      (route_q ? $stable(port0_out_o[0]) : $stable(port1_out_o[3])))
    else $error("unrouted pin moves");
  a_oe_dir: assert property (
    bus_wr_i && bus_addr_i == mct_pkg::ADDR_PORT0_DIR |->
      ##2 port0_oe_o == ~$past(bus_wdata_i, 2)) else $error("driver enable wrong");
  a_full_cause: assert property (
    $rose(tx_buffer_full_o) |-> $past(tx_wr) || $past(tx_wr, 2) || $past(tx_wr, 3))
    else $error("buffer full without write");
  a_flush_full: assert property (
    ctl_wr && !bus_wdata_i[7] |-> ##3 !tx_buffer_full_o) else $error("stop keeps buffer");
  a_status_bits: assert property (
    bus_rd_i && bus_addr_i == mct_pkg::ADDR_CODER_STATUS |-> ##2 bus_rdata_o[6:0] == 7'h00)
    else $error("status spare bits set");
endmodule : mct_checker

//--- mct_top_test.sv
`timescale 1ns/1ps
module mct_top_test;
  localparam logic [15:0] RA [10] = '{16'hff20, 16'hff21, 16'hff60, 16'hff61, 16'hff62,
    16'hff63, 16'hff64, 16'hff65, 16'hff70, 16'hff40};
  localparam logic [7:0] RV [10] = '{8'hff, 8'hff, 8'h10, 8'h00, 8'h1f, 8'h00, 8'hff,
    8'h07, 8'h00, 8'h00};
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] bus_addr_i = 16'h0000;
  logic bus_wr_i = 1'b0;
  logic bus_rd_i = 1'b0;
  logic [7:0] bus_wdata_i = 8'h00;
  logic [7:0] bus_rdata_o, port0_out_o, port0_oe_o, port1_out_o, port1_oe_o;
  logic tx_start_interrupt_o, tx_buffer_full_o, line;
  logic route = 1'b0;
  logic [1023:0] hist;
  logic bits[$];
  logic [31:0] rng = 32'h0000_af54;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  int irqs = 0;

  always #50 ref_clk_i = ~ref_clk_i;
  // undriven pin floats to the pull-up
  assign line = route ? (port1_oe_o[3] ? port1_out_o[3] : 1'b1)
                      : (port0_oe_o[0] ? port0_out_o[0] : 1'b1);

  mct_top u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_addr_i(bus_addr_i),
    .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_wdata_i(bus_wdata_i),
    .bus_rdata_o(bus_rdata_o), .port0_out_o(port0_out_o), .port0_oe_o(port0_oe_o),
    .port1_out_o(port1_out_o), .port1_oe_o(port1_oe_o),
    .tx_start_interrupt_o(tx_start_interrupt_o), .tx_buffer_full_o(tx_buffer_full_o));
  mct_rx_model u_rx (.ref_clk_i(ref_clk_i), .line_i(line), .hist_o(hist));

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge ref_clk_i) begin
    cyc++;
    if (tx_start_interrupt_o === 1'b1) begin
      irqs++;
    end
    if (cyc == 40000) begin
      err_total++;
      report_and_stop();
    end
  end

  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : rnd

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    bus_addr_i = a;
    bus_wdata_i = d;
    bus_wr_i = 1'b1;
    @(negedge ref_clk_i);
    bus_wr_i = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge ref_clk_i);
    bus_addr_i = a;
    bus_rd_i = 1'b1;
    @(negedge ref_clk_i);
    bus_rd_i = 1'b0;
    @(negedge ref_clk_i);
    d = bus_rdata_o;
  endtask : rd

  task automatic wait_irq();
    int n = 0;
    while (tx_start_interrupt_o !== 1'b1 && n < 300) begin
      @(negedge ref_clk_i);
      n++;
    end
    check(n < 300, 1'b1);
  endtask : wait_irq

  task automatic add_unit(input logic [7:0] d, input int n, input logic lsb);
    for (int i = 0; i < n; i++) begin
      bits.push_back(lsb ? d[i] : d[n - 1 - i]);
    end
  endtask : add_unit

  // slides the frame over start offsets; the first base tick may be cut short
  function automatic logic frame_ok(input logic man, input logic idle, input int p,
      input int bt, input int w);
    logic e;
    int s;
    // negative offsets cover a first bit cut short by up to one base tick
    for (int d = -32; d < 48; d++) begin
      frame_ok = 1'b1;
      for (int i = 0; i < w; i++) begin
        s = w - 1 - i - d;
        e = (s < 0 || s >= bits.size() * p) ? idle : bits[s / p] ^ (man && (s % p) >= p / 2);
        if (hist[i] !== e && !(s >= 0 && s < bt)) frame_ok = 1'b0;
      end
      if (frame_ok) return 1'b1;
    end
    return 1'b0;
  endfunction : frame_ok

  task automatic frame(input logic [2:0] code, input logic [4:0] kf, input logic rt,
      input logic lsb, input logic man, input logic idle, input int n, input logic [7:0] d,
      input int more);
    int p;
    int w;
    logic [7:0] v;
    p = 2 * (kf < 5'h04 ? 4 : int'(kf)) * (1 << code);
    bits.delete();
    wr(16'hff60, 8'h00);
    wr(16'hff61, {5'h00, code});
    wr(16'hff62, {3'h0, kf});
    wr(16'hff70, {3'h0, rt, 4'h0});
    route = rt;
    wr(16'hff60, {1'b1, 2'h0, lsb, 2'h0, ~man, idle});
    wr(16'hff65, 8'(n - 1));
    wr(16'hff64, d);
    wait_irq();
    add_unit(d, n, lsb);
    for (int j = 0; j < more; j++) begin
      wr(16'hff65, 8'h07);
      if (j == 2) check(tx_buffer_full_o, 1'b1);
      wr(16'hff64, d + 8'(j + 1));
      if (j < 2) add_unit(d + 8'(j + 1), 8, lsb);
    end
    rd(16'hff63, v);
    check(v, 8'h80);
    w = 4 * more + 6 + bits.size() * p + 60;
    repeat (bits.size() * p + 60) @(negedge ref_clk_i);
    check(frame_ok(man, idle, p, 1 << code, w), 1'b1);
    rd(16'hff63, v);
    check(v, 8'h00);
    $display("frame done code %0d k field %0d bits %0d", code, kf, bits.size());
  endtask : frame

  initial begin
    logic [7:0] v;
    logic [31:0] r;
    int n0;
    repeat (20) @(negedge ref_clk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 10; i++) begin
      rd(RA[i], v);
      check(v, RV[i]);
    end
    $display("register defaults done");
    n0 = irqs;
    wr(16'hff64, 8'h3c);
    repeat (20) @(negedge ref_clk_i);
    check(irqs, n0);
    rd(16'hff64, v);
    check(v, 8'h3c);
    wr(16'hff20, 8'hfe);
    wr(16'hff21, 8'hf7);
    wr(16'hff00, 8'h00);
    wr(16'hff01, 8'h00);
    @(negedge ref_clk_i);
    check({port0_oe_o[1:0], port1_oe_o[3]}, 3'h3);
    $display("stopped unit and pin setup done");
    for (int c = 0; c < 6; c++) begin
      frame(3'(c), c[0] ? 5'h03 : 5'h04, c[0], c[0], c[1], c[2], 6 - c, 8'h6b, 0);
    end
    frame(3'h0, 5'h1f, 1'b0, 1'b0, 1'b1, 1'b1, 8, 8'hc5, 0);
    frame(3'h0, 5'h04, 1'b0, 1'b1, 1'b1, 1'b1, 8, 8'h93, 1);
    frame(3'h0, 5'h04, 1'b1, 1'b0, 1'b0, 1'b0, 8, 8'h2e, 3);
    // late second write: its unit waits two base clocks past the gapless slot
    wr(16'hff60, 8'h00);
    wr(16'hff61, 8'h00);
    wr(16'hff62, 8'h04);
    wr(16'hff60, 8'h80);
    wr(16'hff65, 8'h00);
    wr(16'hff64, 8'h01);
    wait_irq();
    repeat (3) @(negedge ref_clk_i);
    wr(16'hff64, 8'h00);
    n0 = 5;
    while (tx_start_interrupt_o !== 1'b1 && n0 < 40) begin
      @(negedge ref_clk_i);
      n0++;
    end
    check(n0, 2 * 4 + 2);
    wr(16'hff64, 8'h02);
    wr(16'hff64, 8'h03);
    @(negedge ref_clk_i);
    check(tx_buffer_full_o, 1'b1);
    $display("late follow-on done");
    repeat (12) begin
      r = rnd();
      frame(3'(r[1:0] % 2'h3), 5'(r[7:4] % 4'ha), r[8], r[9], r[10], r[11],
        int'(r[14:12]) + 1, r[23:16], 0);
    end
    report_and_stop();
  end
endmodule : mct_top_test

bind mct_top mct_checker u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
  .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o), .port0_out_o(port0_out_o),
  .port0_oe_o(port0_oe_o), .port1_out_o(port1_out_o), .port1_oe_o(port1_oe_o),
  .tx_start_interrupt_o(tx_start_interrupt_o), .tx_buffer_full_o(tx_buffer_full_o));
